// ### dv/scsi_assertions.sv
// Port-level assertions for the smart card unit
module scsi_checker (
  // Clock and reset
  input logic        core_clk,
  input logic        arst_n,
  // Bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [31:0] s_axi_rdata,
  // Controller, requests and pins
  input logic        xfer_wr,
  input logic        xfer_rd,
  input logic        rx_error_irq,
  input logic        rx_full_irq,
  input logic        tx_empty_irq,
  input logic        io_oe,
  input logic        pins_serial
);
  timeunit 1ns;
  timeprecision 100ps;
  // ***********
  // Properties
  // ***********
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_bvalid_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  a_ar_blocked:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready while answer pending");
  a_aw_blocked:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Both channels taken together by this master
  a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_pins_owned:
    assert property (!pins_serial |-> !io_oe)
    else $error("line driven while pins not serial");
  a_rd_clears:
    assert property (xfer_rd |=> !rx_full_irq)
    else $error("controller read left full set");
  a_wr_clears:
    assert property (xfer_wr |=> !tx_empty_irq)
    else $error("controller write left empty set");

  c_tx_end: cover property ($rose(tx_empty_irq));
  c_rx_full: cover property ($rose(rx_full_irq));
  c_rx_err: cover property ($rose(rx_error_irq));
endmodule

bind scsi_top scsi_checker scsi_checker_i (.core_clk, .arst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .xfer_wr, .xfer_rd, .rx_error_irq, .rx_full_irq,
  .tx_empty_irq, .io_oe, .pins_serial);

// ### dv/scsi_card.sv
// Behavioural IC card on the shared open-drain I/O line
module scsi_card (
  // Clock and line
  input  logic core_clk,
  input  logic line,
  // Pull-down drive of the line
  output logic card_low
);
  timeunit 1ns;
  timeprecision 100ps;
  // ***********
  // Card state
  // ***********
  int         etu = 32;
  int         nack_left = 0;
  int         cyc = 0;
  int         last_end = -1;
  int         min_gap;
  bit         sending = 0;
  bit         err_seen;
  logic [8:0] rx_q [$];
  int         start_q [$];

  // Cycle count used to time frames and guard gaps
  always @(posedge core_clk) cyc <= cyc + 1;

  // capture frames mid-bit, send error signal when asked
  initial begin : rx_loop
    logic [8:0] r;
    int         s;
    card_low = 1'b0;
    forever begin
      @(negedge line);
      if (!sending) begin
        s = cyc;
        if (last_end >= 0 && s - last_end < min_gap) min_gap = s - last_end;
        repeat (etu / 2) @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
          repeat (etu) @(posedge core_clk);
          r[i] = line;
        end
        last_end = s + 10 * etu;
        rx_q.push_back(r);
        start_q.push_back(s);
        if (nack_left > 0) begin
          nack_left--;
          repeat (etu) @(posedge core_clk);
          card_low <= 1'b1;
          repeat (etu) @(posedge core_clk);
          card_low <= 1'b0;
        end
      end
    end
  end

  // send one frame, then look for an error signal at 11 etu
  task automatic send(input logic [8:0] b);
    sending = 1'b1;
    card_low <= 1'b1;
    repeat (etu) @(posedge core_clk);
    for (int i = 0; i < 9; i++) begin
      card_low <= !b[i];
      repeat (etu) @(posedge core_clk);
    end
    card_low <= 1'b0;
    repeat (etu) @(posedge core_clk);
    err_seen = !line;
    repeat (2 * etu) @(posedge core_clk);
    sending = 1'b0;
  endtask
endmodule

// ### dv/scsi_top_tb.sv
// Self-checking bench for the smart card unit
module scsi_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // *********************
  // Signals and instances
  // *********************
  logic        core_clk, arst_n, clk_en, xfer_wr, xfer_rd, card_low, block_transfer_mode, inv, bad, ck;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, xfer_wdata, xfer_rdata, d, d2;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr, br;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, rx_error_irq, rx_full_irq, tx_empty_irq;
  logic        io_in, io_out, io_oe, sck_out, sck_oe, pins_serial;
  logic [8:0]  exp_q [$];
  int          bad_count = 0, compares = 0, cycles = 0, ic, e;
  int          ratio [4] = '{32, 64, 372, 256};

  scsi_top scsi_top_i (.*);
  scsi_card scsi_card_i (.core_clk, .line(io_in), .card_low);
  // Pulled-up line: low while either side pulls it
  assign io_in = io_oe ? io_out : !card_low;

  // Core clock at 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    while (!(aw && w)) begin
      @(posedge core_clk);
      if (s_axi_awready) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge core_clk); while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // Let an edge pass so a following call does not raise bready in this step
    @(posedge core_clk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check(rd, exp);
    @(posedge core_clk);
  endtask

  // Line levels of a frame, first bit in bit 0, parity last
  function automatic logic [8:0] enc(input logic [7:0] v, input logic iv);
    logic [8:0] r;
    for (int i = 0; i < 8; i++) r[i] = iv ? !v[7-i] : v[i];
    r[8] = ^r[7:0] ^ iv;
    return r;
  endfunction

  // ordered start-up, error flags cleared, odd parity for inverse
  task automatic cfg(input logic iv, input logic bk, input logic g, input int rs,
                     input logic [7:0] ctl);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'hc4);
    wr(8'h00, {24'h0, g, bk, 1'b1, iv, rs[1:0], 2'b00});
    wr(8'h04, {28'h0, iv, iv, 2'b01});
    wr(8'h18, 32'h0);
    wr(8'h08, 32'h01);
    scsi_card_i.etu = ratio[rs];
    scsi_card_i.last_end = -1;
    scsi_card_i.min_gap = 99999;
    scsi_card_i.rx_q.delete();
    scsi_card_i.start_q.delete();
    repeat (ratio[rs]) @(posedge core_clk);
    wr(8'h08, {24'h0, ctl});
    check(sck_oe, 1'b1);
    check(pins_serial, 1'b1);
    // With a zero bit rate the card clock toggles on every edge
    ck = sck_out;
    @(posedge core_clk);
    check(sck_out, !ck);
  endtask

  task automatic send_tx(input logic [7:0] v);
    xfer_wdata <= v;
    xfer_wr <= 1'b1;
    @(posedge core_clk);
    xfer_wr <= 1'b0;
    do @(posedge core_clk); while (!tx_empty_irq);
    ic = scsi_card_i.cyc;
  endtask

  task automatic report_and_stop();
    $display("compares=%0d mismatches=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence: reset, transmit cases, receive cases
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, xfer_wdata, xfer_wr, xfer_rd} <= '0;
    s_axi_wstrb <= 4'h1;
    clk_en <= 1'b1;
    arst_n <= 1'b0;
    void'($urandom(33));
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    check(io_oe, 1'b0);
    check(io_out, 1'b0);
    rchk(8'h0c, 32'h84);
    rchk(8'h18, 32'hff);
    rchk(8'h1c, 32'h0);
    check(rr, 2'b10);
    wr(8'h1c, 32'h5a);
    check(br, 2'b10);
    $display("reset test done");
    // Bit 0 of t picks the convention, bit 1 block mode; test 1 adds clock fix mode
    for (int t = 0; t < 4; t++) begin
      inv = t[0];
      block_transfer_mode = t[1];
      d = (t == 0) ? 8'h3b : (t == 1) ? 8'h3f : 8'($urandom);
      d2 = 8'($urandom);
      cfg(inv, block_transfer_mode, t == 1, 0, 8'he1);
      scsi_card_i.nack_left = 1;
      exp_q = '{enc(d, inv)};
      if (!block_transfer_mode) exp_q.push_back(enc(d, inv));
      exp_q.push_back(enc(d2, inv));
      send_tx(d);
      e = scsi_card_i.start_q[$] + (block_transfer_mode ? 368 : (t == 1) ? 352 : 400) - ic;
      check(e >= -4 && e <= 4, 1'b1);
      rchk(8'h0c, 32'h84 | {!block_transfer_mode, 4'h0});
      check(rx_error_irq, !block_transfer_mode);
      wr(8'h0c, 32'hc4);
      send_tx(d2);
      repeat (64) @(posedge core_clk);
      check(scsi_card_i.rx_q.size(), exp_q.size());
      foreach (exp_q[i]) check(scsi_card_i.rx_q[i], exp_q[i]);
      check(scsi_card_i.min_gap >= (block_transfer_mode ? 32 : 64), 1'b1);
      $display("tx test %0d done", t);
    end
    // Four ratios with good parity, then a parity error in normal and block mode
    for (int t = 0; t < 6; t++) begin
      bad = (t > 3);
      block_transfer_mode = (t == 5);
      cfg(1'b0, block_transfer_mode, 1'b0, (t < 4) ? t : 0, 8'h51);
      d = 8'($urandom);
      scsi_card_i.send(enc(d, 1'b0) ^ {bad, 8'h00});
      check(scsi_card_i.err_seen, bad && !block_transfer_mode);
      check(rx_full_irq, !bad);
      check(rx_error_irq, bad);
      check(xfer_rdata, d);
      // Controller read first, so the bus read below cannot clear the flag for it
      xfer_rd <= 1'b1;
      @(posedge core_clk);
      xfer_rd <= 1'b0;
      @(posedge core_clk);
      check(rx_full_irq, 1'b0);
      rchk(8'h14, d);
      $display("rx test %0d done", t);
    end
    report_and_stop();
  end
endmodule

// ### hdl/scsi_card_clk.v
// Card clock output generator with level fixing that keeps the pulse width
module scsi_card_clk (
  // Clock and reset
  input  wire core_clk,
  input  wire arst_n,
  input  wire clk_en,
  // Control
  input  wire basic_tick,
  input  wire out_enable,
  input  wire fix_mode,
  input  wire fix_level,
  // Pin
  output reg  sck_out,
  output reg  sck_oe
);
  // Toggle on basic ticks; when halted under fix mode, only stop at the fixed level
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sck_out <= 1'b0;
      sck_oe  <= 1'b0;
    end else if (clk_en) begin
      sck_oe <= out_enable | fix_mode;
      if (out_enable) begin
        if (basic_tick)
          sck_out <= ~sck_out;
      end else if (fix_mode) begin
        // Wait for the natural edge so no short pulse appears
        if (basic_tick && sck_out != fix_level)
          sck_out <= fix_level;
      end else begin
        sck_out <= fix_level;
      end
    end
  end
endmodule

// ### hdl/scsi_etu_gen.v
// Basic-clock divider and half-etu tick generator of the smart card unit
`include "scsi_map.vh"
module scsi_etu_gen (
  // Clock and reset
  input  wire       core_clk,
  input  wire       arst_n,
  input  wire       clk_en,
  // Configuration
  input  wire [7:0] bit_rate,
  input  wire [1:0] ratio_sel,
  input  wire       restart,
  // Ticks
  output reg        basic_tick,
  output reg        half_tick
);
  reg [7:0] pre_q;
  reg [8:0] bas_q;
  reg [8:0] half_lim;

  // basic clock ratio
  // Half of 32, 64, 372, 256 basic clocks; mid-bit lands on pulse 16, 32, 186, 128
  always @* begin
    case (ratio_sel)
      2'b00:   half_lim = 9'd15;
      2'b01:   half_lim = 9'd31;
      2'b10:   half_lim = 9'd185;
      2'b11:   half_lim = 9'd127;
      default: half_lim = 9'd15;
    endcase
  end

  // Prescaler then basic clock count; restart aligns to a start edge
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q      <= 8'h00;
      bas_q      <= 9'h000;
      basic_tick <= 1'b0;
      half_tick  <= 1'b0;
    end else if (clk_en) begin
      basic_tick <= 1'b0;
      half_tick  <= 1'b0;
      if (restart) begin
        pre_q <= 8'h00;
        bas_q <= 9'h000;
      end else if (pre_q >= bit_rate) begin
        pre_q      <= 8'h00;
        basic_tick <= 1'b1;
        if (bas_q >= half_lim) begin
          bas_q     <= 9'h000;
          half_tick <= 1'b1;
        end else begin
          bas_q <= bas_q + 9'd1;
        end
      end else begin
        pre_q <= pre_q + 8'd1;
      end
    end
  end
endmodule

// ### hdl/scsi_map.vh
// Register offsets, field positions, reset values and timing counts of the smart card unit
`ifndef SCSI_MAP_VH
`define SCSI_MAP_VH
// ********************************
// Register byte offsets
// ********************************
`define SCSI_OFF_MODE    8'h00
`define SCSI_OFF_SCMODE  8'h04
`define SCSI_OFF_CTRL    8'h08
`define SCSI_OFF_STATUS  8'h0c
`define SCSI_OFF_TXDATA  8'h10
`define SCSI_OFF_RXDATA  8'h14
`define SCSI_OFF_BITRATE 8'h18
// ********************************
// Field positions
// ********************************
`define SCSI_MODE_GM     7
`define SCSI_MODE_BLK    6
`define SCSI_MODE_PAR_EN 5
`define SCSI_MODE_ODD    4
`define SCSI_MODE_BCP_LO 2
`define SCSI_SC_ENABLE   0
`define SCSI_SC_INVERT   2
`define SCSI_SC_MSB      3
`define SCSI_CT_TIE      7
`define SCSI_CT_RIE      6
`define SCSI_CT_TE       5
`define SCSI_CT_RE       4
`define SCSI_CT_CLOCK_LEVEL_FIX     1
`define SCSI_CT_CLOCK_OUTPUT_ENABLE     0
`define SCSI_ST_TX_DATA_EMPTY_FLAG     7
`define SCSI_ST_RX_DATA_FULL_FLAG     6
`define SCSI_ST_OVERRUN_ERROR_FLAG     5
`define SCSI_ST_ERS      4
`define SCSI_ST_PER      3
`define SCSI_ST_TRANSMIT_END_FLAG     2
// ********************************
// Reset values
// ********************************
`define SCSI_RST_STATUS  8'h84
`define SCSI_RST_BITRATE 8'hff
// ********************************
// Timing in half-etu units
// ********************************
`define SCSI_HALF_ERR_START 5'd21
`define SCSI_HALF_ERR_END   5'd23
`define SCSI_HALF_ERR_SMP   5'd22
`define SCSI_HALF_TRANSMIT_END_FLAG_BLK  5'd23
`define SCSI_HALF_TRANSMIT_END_FLAG_NRM  5'd25
`define SCSI_HALF_TRANSMIT_END_FLAG_GM   5'd22
`define SCSI_HALF_END_NRM   5'd26
`define SCSI_HALF_END_BLK   5'd23
`define SCSI_HALF_RETRY     5'd30
`endif

// ### hdl/scsi_top.v
// Smart card serial interface: AXI4-Lite registers, transmitter, receiver
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`include "scsi_map.vh"
module scsi_top (
  // Clock and reset
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        clk_en,
  // AXI4-Lite write address
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Transfer controller access
  input  wire        xfer_wr,
  input  wire [7:0]  xfer_wdata,
  input  wire        xfer_rd,
  output wire [7:0]  xfer_rdata,
  // Request lines
  output wire        rx_error_irq,
  output wire        rx_full_irq,
  output wire        tx_empty_irq,
  // Card I/O line
  input  wire        io_in,
  output wire        io_out,
  output wire        io_oe,
  // Card clock pin
  output wire        sck_out,
  output wire        sck_oe,
  // Pin ownership
  output wire        pins_serial
);
  // ********************************
  // Registers
  // ********************************
  reg [7:0] mode_q, scm_q, ctrl_q, brr_q, tdr_q, rdr_q;
  reg       tx_data_empty_flag_q, rx_data_full_flag_q, overrun_error_flag_q, ers_q, per_q, transmit_end_flag_q;
  reg       aw_q, w_q;
  reg [7:0] awa_q;
  reg [7:0] wd_q;
  reg [3:0] tst_q, rst_q;
  reg [4:0] tha_q, rha_q;
  reg [3:0] tbit_q, rbit_q;
  reg [8:0] tsr_q, rsr_q;
  reg       tline_q, rline_q, tpend_q, errseen_q, rx_prev_q;

  wire block_transfer_mode    = mode_q[`SCSI_MODE_BLK];
  wire gm     = mode_q[`SCSI_MODE_GM];
  wire odd    = mode_q[`SCSI_MODE_ODD];
  wire data_invert   = scm_q[`SCSI_SC_INVERT];
  wire bit_order_msb_first   = scm_q[`SCSI_SC_MSB];
  wire smartcard_enable   = scm_q[`SCSI_SC_ENABLE];
  wire te     = ctrl_q[`SCSI_CT_TE];
  wire re     = ctrl_q[`SCSI_CT_RE];
  wire half_tick;
  wire basic_tick;

  // Bit reorder and data invert, used on both directions
  function [7:0] conv;
    input [7:0] d;
    input       msb;
    input       inv;
    integer     i;
    reg [7:0]   r;
    begin
      for (i = 0; i < 8; i = i + 1)
        r[i] = msb ? d[7 - i] : d[i];
      conv = inv ? ~r : r;
    end
  endfunction

  // ********************************
  // AXI4-Lite slave
  // ********************************
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire   do_wr = aw_q && w_q && !s_axi_bvalid;
  wire   rd_go = s_axi_arvalid && s_axi_arready;
  wire   wr_tdr  = (do_wr && awa_q == `SCSI_OFF_TXDATA) || xfer_wr;
  wire   wr_stat = do_wr && awa_q == `SCSI_OFF_STATUS;
  wire   rd_rdr  = (rd_go && s_axi_araddr == `SCSI_OFF_RXDATA) || xfer_rd;
  wire [7:0] tdr_new = xfer_wr ? xfer_wdata : wd_q;
  wire [7:0] status = {tx_data_empty_flag_q, rx_data_full_flag_q, overrun_error_flag_q, ers_q & ~block_transfer_mode, per_q, transmit_end_flag_q, 2'b00};
  assign xfer_rdata = rdr_q;

  // Capture address and data in either order, then write
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 8'h00;
      s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'b00;
      mode_q <= 8'h00; scm_q <= 8'h00; ctrl_q <= 8'h00; brr_q <= `SCSI_RST_BITRATE;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q  <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q  <= 1'b1;
        wd_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      if (do_wr) begin
        aw_q <= 1'b0; w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (awa_q)
          `SCSI_OFF_MODE:    mode_q <= wd_q;
          `SCSI_OFF_SCMODE:  scm_q  <= wd_q & 8'h0d;
          `SCSI_OFF_CTRL:    ctrl_q <= wd_q;
          `SCSI_OFF_BITRATE: brr_q  <= wd_q;
          `SCSI_OFF_STATUS, `SCSI_OFF_TXDATA, `SCSI_OFF_RXDATA: s_axi_bresp <= 2'b00;
          default:           s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read mux; unmapped addresses answer SLVERR with zero data
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0000_0000; s_axi_rresp <= 2'b00;
    end else if (clk_en) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `SCSI_OFF_MODE:    s_axi_rdata <= {24'h000000, mode_q};
          `SCSI_OFF_SCMODE:  s_axi_rdata <= {24'h000000, scm_q};
          `SCSI_OFF_CTRL:    s_axi_rdata <= {24'h000000, ctrl_q};
          `SCSI_OFF_STATUS:  s_axi_rdata <= {24'h000000, status};
          `SCSI_OFF_TXDATA:  s_axi_rdata <= {24'h000000, tdr_q};
          `SCSI_OFF_RXDATA:  s_axi_rdata <= {24'h000000, rdr_q};
          `SCSI_OFF_BITRATE: s_axi_rdata <= {24'h000000, brr_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ********************************
  // Shared timing
  // ********************************
  // internal generator only
  wire rx_fall  = re && rst_q == 4'd0 && rx_prev_q && !io_in;
  scsi_etu_gen u_etu (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .bit_rate   (brr_q),
    .ratio_sel  (mode_q[`SCSI_MODE_BCP_LO+1:`SCSI_MODE_BCP_LO]),
    .restart    (rx_fall || (te && tst_q == 4'd0 && tpend_q)),
    .basic_tick (basic_tick),
    .half_tick  (half_tick)
  );

  scsi_card_clk u_clk (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .clk_en     (clk_en),
    .basic_tick (basic_tick),
    .out_enable (ctrl_q[`SCSI_CT_CLOCK_OUTPUT_ENABLE]),
    .fix_mode   (gm),
    .fix_level  (ctrl_q[`SCSI_CT_CLOCK_LEVEL_FIX]),
    .sck_out    (sck_out),
    .sck_oe     (sck_oe)
  );

  assign pins_serial = smartcard_enable;
  // Open-drain style: drive only low; line released otherwise
  assign io_out = 1'b0;
  assign io_oe  = smartcard_enable && (!tline_q || !rline_q);

  // ********************************
  // Transmitter
  // ********************************
  // States: idle, frame, guard
  localparam T_IDLE = 4'd0, T_RUN = 4'd1, T_WAIT = 4'd2;
  // flag point by block and clock fix mode; end point by block mode only
  wire [4:0] transmit_end_flag_pt = block_transfer_mode ? `SCSI_HALF_TRANSMIT_END_FLAG_BLK : (gm ? `SCSI_HALF_TRANSMIT_END_FLAG_GM : `SCSI_HALF_TRANSMIT_END_FLAG_NRM);
  wire [4:0] transmit_end_flag_at = block_transfer_mode ? `SCSI_HALF_END_BLK : `SCSI_HALF_END_NRM;
  wire       err_blk = overrun_error_flag_q || per_q;

  // Frame sequencer in half-etu steps from the start bit
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tst_q <= T_IDLE; tha_q <= 5'd0; tsr_q <= 9'h1ff; tline_q <= 1'b1;
      tpend_q <= 1'b0; errseen_q <= 1'b0;
    end else if (clk_en) begin
      if (!te) begin
        tst_q <= T_IDLE; tline_q <= 1'b1; tpend_q <= 1'b0;
      end else begin
        if (wr_tdr)
          tpend_q <= 1'b1;
        case (tst_q)
          T_IDLE: begin
            if (tpend_q && !err_blk) begin
              // parity on converted data, odd select inverts it
              tsr_q     <= {(^conv(tdr_q, bit_order_msb_first, data_invert)) ^ odd, conv(tdr_q, bit_order_msb_first, data_invert)};
              tline_q   <= 1'b0;
              tha_q     <= 5'd0;
              errseen_q <= 1'b0;
              tpend_q   <= 1'b0;
              tst_q     <= T_RUN;
            end
          end
          T_RUN: begin
            if (half_tick) begin
              tha_q <= tha_q + 5'd1;
              if (tha_q[0] && tha_q < 5'd19) begin
                tline_q <= tsr_q[0];
                tsr_q   <= {1'b1, tsr_q[8:1]};
              end else if (tha_q == 5'd19) begin
                tline_q <= 1'b1;
              end
              if (tha_q + 5'd1 == `SCSI_HALF_ERR_SMP && !block_transfer_mode && !io_in)
                errseen_q <= 1'b1;
              if (tha_q + 5'd1 == transmit_end_flag_at) begin
                tst_q <= T_WAIT;
                tha_q <= 5'd0;
              end
            end
          end
          T_WAIT: begin
            if (errseen_q) begin
              if (half_tick)
                tha_q <= tha_q + 5'd1;
              if (half_tick && tha_q == 5'd3) begin
                tpend_q <= 1'b1;
                tst_q   <= T_IDLE;
              end
            end else begin
              tst_q <= T_IDLE;
            end
          end
          default: tst_q <= T_IDLE;
        endcase
      end
    end
  end

  // ********************************
  // Receiver
  // ********************************
  localparam R_IDLE = 4'd0, R_RUN = 4'd1;
  wire [7:0] rx_byte = conv(rsr_q[7:0], bit_order_msb_first, data_invert);
  wire       par_bad = ((^rsr_q[7:0]) ^ odd) != rsr_q[8];

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= R_IDLE; rha_q <= 5'd0; rsr_q <= 9'h000; rline_q <= 1'b1;
      rx_prev_q <= 1'b1; rdr_q <= 8'h00;
    end else if (clk_en) begin
      rx_prev_q <= io_in;
      case (rst_q)
        R_IDLE: begin
          rline_q <= 1'b1;
          if (rx_fall) begin
            rha_q <= 5'd0;
            rst_q <= R_RUN;
          end
        end
        R_RUN: begin
          if (!re) begin
            rst_q <= R_IDLE;
          end else if (half_tick) begin
            rha_q <= rha_q + 5'd1;
            if (!rha_q[0] && rha_q >= 5'd2 && rha_q <= 5'd18)
              rsr_q <= {io_in, rsr_q[8:1]};
            if (rha_q == 5'd19) begin
              rdr_q <= rx_byte;
            end
            if (rha_q + 5'd1 == `SCSI_HALF_ERR_START && par_bad && !block_transfer_mode)
              rline_q <= 1'b0;
            if (rha_q + 5'd1 == `SCSI_HALF_ERR_END) begin
              rline_q <= 1'b1;
              rst_q   <= R_IDLE;
            end
          end
        end
        default: rst_q <= R_IDLE;
      endcase
    end
  end

  // ********************************
  // Status flags
  // ********************************
  wire rx_done = rst_q == R_RUN && half_tick && rha_q == 5'd19;
  wire ers_set = tst_q == T_RUN && half_tick && tha_q + 5'd1 == `SCSI_HALF_ERR_SMP &&
                 !block_transfer_mode && !io_in;
  // Under clock fix mode the flag point meets the error sample; the error must win
  wire tx_fin  = tst_q == T_RUN && half_tick && tha_q + 5'd1 == transmit_end_flag_pt && !errseen_q &&
                 !ers_set;

  // Hardware set wins over a simultaneous software or controller clear, except the full flag: a byte done as it is cleared sets overrun instead
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {tx_data_empty_flag_q, rx_data_full_flag_q, overrun_error_flag_q, ers_q, per_q, transmit_end_flag_q} <= 6'b100001;
      tdr_q <= 8'h00;
    end else if (clk_en) begin
      if (wr_tdr)
        tdr_q <= tdr_new;
      tx_data_empty_flag_q <= tx_fin | (tx_data_empty_flag_q & ~wr_tdr & ~(wr_stat & ~wd_q[`SCSI_ST_TX_DATA_EMPTY_FLAG]));
      transmit_end_flag_q <= tx_fin | (transmit_end_flag_q & ~wr_tdr);
      rx_data_full_flag_q <= (rx_done & ~par_bad & ~rx_data_full_flag_q) |
                (rx_data_full_flag_q & ~rd_rdr & ~(wr_stat & ~wd_q[`SCSI_ST_RX_DATA_FULL_FLAG]));
      overrun_error_flag_q <= (rx_done & ~par_bad & rx_data_full_flag_q) | (overrun_error_flag_q & ~(wr_stat & ~wd_q[`SCSI_ST_OVERRUN_ERROR_FLAG]));
      per_q  <= (rx_done & par_bad) | (per_q & ~(wr_stat & ~wd_q[`SCSI_ST_PER]));
      ers_q  <= ers_set | (ers_q & ~(wr_stat & ~wd_q[`SCSI_ST_ERS]));
    end
  end

  assign rx_error_irq = ctrl_q[`SCSI_CT_RIE] & (per_q | overrun_error_flag_q | (ers_q & ~block_transfer_mode));
  assign rx_full_irq  = ctrl_q[`SCSI_CT_RIE] & rx_data_full_flag_q;
  assign tx_empty_irq = ctrl_q[`SCSI_CT_TIE] & transmit_end_flag_q & te;
endmodule
